// [eth_media_pkg.sv]
/*
  Types of the packet port media interface: port mode and transmit states.
  Assumes nothing of its surroundings.
*/
package eth_media_pkg;
  typedef enum logic [1:0] {mode_mii, mode_gmii, mode_tbi} port_mode_type;
  typedef enum logic [1:0] {tx_idle, tx_send, tx_gap} tx_state_type;
endpackage

// [eth_media_regs.svh]
/*
  Constants of the packet port media interface: buffer shape, word layout
  of the transmit buffer and the false-carrier codes.
  Assumes inclusion by bare name from the design file only.
*/
`ifndef ETH_MEDIA_REGS_SVH
`define ETH_MEDIA_REGS_SVH

`define TX_FIFO_DEPTH 32
`define TX_FIFO_WIDTH 11
`define TX_WORD_LAST 10
`define TX_WORD_BIT9 9
`define TX_WORD_BIT8 8
`define MII_FALSE_CARRIER 4'he
`define GMII_FALSE_CARRIER 8'h0e

`endif

// [eth_phy_model.sv]
/*
  behavioural phy / serdes on the far side of the media pins: free-running
  receive and transmit clocks, receive pin drivers and sense lines.
  assumes the bench places receive symbols through the tasks below.
*/
`timescale 1ns/10ps
module eth_phy_model (
  output logic p0_receive_clock,
  output logic rx_byte_clock_phase_a,
  output logic rx_byte_clock_phase_b,
  output logic p0_transmit_clock_in,
  output logic p1_receive_clock,
  output logic p1_transmit_clock_in,
  output logic [7:0] p0_receive_bus,
  output logic p0_receive_valid,
  output logic p0_receive_error,
  output logic p0_collision_in,
  output logic p0_carrier_sense,
  output logic p0_signal_present,
  output logic [3:0] p1_receive_bus,
  output logic p1_receive_valid,
  output logic p1_receive_error,
  output logic p1_collision_in,
  output logic p1_carrier_sense
);
  initial
  begin
    {p0_receive_clock, p1_receive_clock, p0_transmit_clock_in} = 3'h0;
    {p1_transmit_clock_in, rx_byte_clock_phase_a, rx_byte_clock_phase_b} = 3'h1;
    {p0_receive_error, p0_receive_valid, p0_receive_bus} = 10'h000;
    {p1_receive_error, p1_receive_valid, p1_receive_bus} = 6'h00;
    {p0_carrier_sense, p0_collision_in, p0_signal_present} = 3'h0;
    {p1_carrier_sense, p1_collision_in} = 2'h0;
  end
  always #16 p0_receive_clock = ~p0_receive_clock;
  always #16 p1_receive_clock = ~p1_receive_clock;
  // transmit clocks at the nibble rate
  always #20 p0_transmit_clock_in = ~p0_transmit_clock_in;
  always #20 p1_transmit_clock_in = ~p1_transmit_clock_in;
  always #8
  begin
    rx_byte_clock_phase_a = ~rx_byte_clock_phase_a;
    rx_byte_clock_phase_b = ~rx_byte_clock_phase_b;
  end
  // pins change away from every sampling edge except the rx_byte_clock_phase_b rise that the mii path lands on
  task p0_drive(input logic [9:0] w, input logic tbi);
    if (tbi)
    begin
      @(posedge rx_byte_clock_phase_a);
      #4;
    end
    else
      @(negedge p0_receive_clock);
    {p0_receive_error, p0_receive_valid, p0_receive_bus} = w;
  endtask
  task p1_drive(input logic [5:0] w);
    @(negedge p1_receive_clock);
    {p1_receive_error, p1_receive_valid, p1_receive_bus} = w;
  endtask
  // sense lines change with no clock
  task sense(input logic [4:0] s);
    {p0_carrier_sense, p0_collision_in, p0_signal_present} = s[4:2];
    {p1_carrier_sense, p1_collision_in} = s[1:0];
  endtask
endmodule

// [ethernet_port_media_interface.sv]
/*
  Media interface of both packet ports: receive capture, carrier and
  collision sensing, transmit framing from a 32-word buffer, gigabit
  transmit clock and the indicator outputs.
  Assumes a 250 MHz tx_fast_clock for the gigabit launch logic, a PHY or
  SerDes on the pins, and one asynchronous reset for every domain.
*/
// Functional notes
// - tbi: two antiphase byte clocks each sample
// - mii/gmii sample on rx clock; mii low nibble
// - tbi: valid and error pins are bits 8, 9
// - receive-valid marks valid frame data
// - error with valid: frame error; else false carrier on code e (0e in gmii)
// - carrier sense synchronised; signal-detect in tbi
// - mii launches on tx clock; else gigabit clock
// - enable held from preamble to last data
// - transmit error with enable: invalid symbol
// - tbi: enable and error pins carry bits 8, 9
// - gigabit transmit clock output in gmii/tbi
// - link and activity indicators active low
// - port 1 is mii only
// - tbi auto-negotiation off until software enables
// - pause frames never stop transmission
`timescale 1ns/10ps
`include "eth_media_regs.svh"

module sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_d;
  // a change is taken only once stages two and three agree
  always_comb
  begin
    q_d = (s2_q == s3_q) ? s3_q : q;
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q <= '0;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q <= q_d;
    end
  end
endmodule

module async_fifo #(
  parameter int WIDTH = `TX_FIFO_WIDTH,
  parameter int DEPTH = `TX_FIFO_DEPTH
) (
  input wire logic wr_clock,
  input wire logic rd_clock,
  input wire logic arst_n,
  input wire logic wr_valid,
  input wire logic [WIDTH-1:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [WIDTH-1:0] rd_data,
  input wire logic rd_ready
);
  localparam int A = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [A:0] wbin_q, wbin_d, wgray_q, wgray_d, rsync;
  logic [A:0] rbin_q, rbin_d, rgray_q, rgray_d, wsync;
  logic ready_d;
  logic push;
  logic pop;

  function automatic logic [A:0] bin2gray(input logic [A:0] b);
    return b ^ (b >> 1);
  endfunction

  // pointers cross as gray code, so a torn sample is off by one at most
  sync3 #(.W(A + 1)) u_rsync (.clk(wr_clock), .arst_n(arst_n), .d(rgray_q), .q(rsync));
  sync3 #(.W(A + 1)) u_wsync (.clk(rd_clock), .arst_n(arst_n), .d(wgray_q), .q(wsync));

  always_comb
  begin
    push = wr_valid && wr_ready;
    wbin_d = wbin_q + (A + 1)'(push);
    wgray_d = bin2gray(wbin_d);
    ready_d = (wgray_d != {~rsync[A:A-1], rsync[A-2:0]});
  end
  always_ff @(posedge wr_clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wbin_q <= '0;
      wgray_q <= '0;
      wr_ready <= 1'b0;
    end
    else
    begin
      wbin_q <= wbin_d;
      wgray_q <= wgray_d;
      wr_ready <= ready_d;
    end
  end
  always_ff @(posedge wr_clock)
  begin
    if (push)
      mem[wbin_q[A-1:0]] <= wr_data;
  end

  always_comb
  begin
    rd_valid = (rgray_q != wsync);
    rd_data = mem[rbin_q[A-1:0]];
    pop = rd_valid && rd_ready;
    rbin_d = rbin_q + (A + 1)'(pop);
    rgray_d = bin2gray(rbin_d);
  end
  always_ff @(posedge rd_clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rbin_q <= '0;
      rgray_q <= '0;
    end
    else
    begin
      rbin_q <= rbin_d;
      rgray_q <= rgray_d;
    end
  end
endmodule

module ethernet_port_media_interface (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic tx_fast_clock,
  input wire logic p0_receive_clock,
  input wire logic rx_byte_clock_phase_a,
  input wire logic rx_byte_clock_phase_b,
  input wire logic p0_transmit_clock_in,
  input wire logic p1_receive_clock,
  input wire logic p1_transmit_clock_in,
  input wire eth_media_pkg::port_mode_type p0_mode,
  input wire logic p0_link_up,
  input wire logic p1_link_up,
  input wire logic autoneg_request,
  output logic p0_autoneg_enable,
  input wire logic tx_valid,
  input wire logic [9:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  input wire logic [7:0] p0_receive_bus,
  input wire logic p0_receive_valid,
  input wire logic p0_receive_error,
  input wire logic p0_collision_in,
  input wire logic p0_carrier_sense,
  input wire logic p0_signal_present,
  output logic [7:0] p0_rx_data,
  output logic p0_rx_data_valid,
  output logic p0_rx_frame_error,
  output logic p0_rx_false_carrier,
  output logic [9:0] p0_tbi_code_a,
  output logic [9:0] p0_tbi_code_b,
  output logic p0_carrier_detect,
  output logic p0_collision_detect,
  output logic [7:0] p0_transmit_bus,
  output logic p0_transmit_enable,
  output logic p0_transmit_error,
  output logic p0_gigabit_tx_clock_out,
  output logic p0_link_indicator_n,
  output logic p0_activity_indicator_n,
  input wire logic [3:0] p1_receive_bus,
  input wire logic p1_receive_valid,
  input wire logic p1_receive_error,
  input wire logic p1_collision_in,
  input wire logic p1_carrier_sense,
  output logic [3:0] p1_rx_data,
  output logic p1_rx_data_valid,
  output logic p1_rx_frame_error,
  output logic p1_rx_false_carrier,
  output logic p1_carrier_detect,
  output logic p1_collision_detect,
  input wire logic p1_tx_valid,
  input wire logic [3:0] p1_tx_data,
  input wire logic p1_tx_error,
  output logic [3:0] p1_transmit_bus,
  output logic p1_transmit_enable,
  output logic p1_transmit_error,
  output logic p1_link_indicator_n,
  output logic p1_activity_indicator_n
);
  import eth_media_pkg::*;

  function automatic logic false_carrier(input logic valid, input logic err,
                                         input logic [7:0] data, input logic mii);
    return !valid && err && (mii ? (data[3:0] == `MII_FALSE_CARRIER)
                                 : (data == `GMII_FALSE_CARRIER));
  endfunction

  // ---------------- core domain: sensing, indicators, pcs control
  logic p0_crs_pin;
  logic [3:0] sense_q;
  logic p0_link_n_d, p0_act_n_d, p1_link_n_d, p1_act_n_d, aneg_d;

  assign p0_crs_pin = (p0_mode == mode_tbi) ? p0_signal_present : p0_carrier_sense;
  sync3 #(.W(4)) u_sense (
    .clk(clock),
    .arst_n(arst_n),
    .d({p1_collision_in, p1_carrier_sense, p0_collision_in, p0_crs_pin}),
    .q(sense_q)
  );
  assign p0_carrier_detect = sense_q[0];
  assign p0_collision_detect = sense_q[1];
  assign p1_carrier_detect = sense_q[2];
  assign p1_collision_detect = sense_q[3];

  always_comb
  begin
    p0_link_n_d = !p0_link_up;
    p1_link_n_d = !p1_link_up;
    // carrier covers both directions, so it doubles as activity
    p0_act_n_d = !sense_q[0];
    p1_act_n_d = !sense_q[2];
    aneg_d = autoneg_request && (p0_mode == mode_tbi);
  end
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      p0_link_indicator_n <= 1'b1;
      p0_activity_indicator_n <= 1'b1;
      p1_link_indicator_n <= 1'b1;
      p1_activity_indicator_n <= 1'b1;
      p0_autoneg_enable <= 1'b0;
    end
    else
    begin
      p0_link_indicator_n <= p0_link_n_d;
      p0_activity_indicator_n <= p0_act_n_d;
      p1_link_indicator_n <= p1_link_n_d;
      p1_activity_indicator_n <= p1_act_n_d;
      p0_autoneg_enable <= aneg_d;
    end
  end

  // ---------------- port 0 receive, mii/gmii
  logic [1:0] rx_mode_raw;
  logic rx_mii;
  logic [7:0] p0_rx_data_d;
  logic p0_dv_d, p0_fe_d, p0_fc_d;

  sync3 #(.W(2)) u_rx_mode (
    .clk(p0_receive_clock), .arst_n(arst_n), .d(p0_mode), .q(rx_mode_raw)
  );
  assign rx_mii = (port_mode_type'(rx_mode_raw) == mode_mii);

  always_comb
  begin
    p0_rx_data_d = rx_mii ? {4'h0, p0_receive_bus[3:0]} : p0_receive_bus;
    p0_dv_d = p0_receive_valid;
    p0_fe_d = p0_receive_valid && p0_receive_error;
    p0_fc_d = false_carrier(p0_receive_valid, p0_receive_error, p0_receive_bus, rx_mii);
  end
  always_ff @(posedge p0_receive_clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      p0_rx_data <= 8'h00;
      p0_rx_data_valid <= 1'b0;
      p0_rx_frame_error <= 1'b0;
      p0_rx_false_carrier <= 1'b0;
    end
    else
    begin
      p0_rx_data <= p0_rx_data_d;
      p0_rx_data_valid <= p0_dv_d;
      p0_rx_frame_error <= p0_fe_d;
      p0_rx_false_carrier <= p0_fc_d;
    end
  end

  // ---------------- port 0 receive, ten-bit on two byte clocks
  logic [9:0] tbi_pins;
  // valid and error pins are bits 8, 9
  assign tbi_pins = {p0_receive_error, p0_receive_valid, p0_receive_bus};
  always_ff @(posedge rx_byte_clock_phase_a or negedge arst_n)
  begin
    if (!arst_n)
      p0_tbi_code_a <= 10'h000;
    else
      p0_tbi_code_a <= tbi_pins;
  end
  always_ff @(posedge rx_byte_clock_phase_b or negedge arst_n)
  begin
    if (!arst_n)
      p0_tbi_code_b <= 10'h000;
    else
      p0_tbi_code_b <= tbi_pins;
  end

  // ---------------- port 0 transmit
  logic [`TX_FIFO_WIDTH-1:0] fifo_word;
  logic fifo_valid, fifo_pop;
  logic [1:0] tx_mode_raw;
  port_mode_type tx_mode;
  logic txclk_lvl, txclk_prev_q, tick;
  tx_state_type state_q, state_d;
  logic half_q, half_d, gtx_d, en_d, err_d, last_sent_q, last_sent_d;
  logic [7:0] bus_d;

  async_fifo #(.WIDTH(`TX_FIFO_WIDTH), .DEPTH(`TX_FIFO_DEPTH)) u_tx_fifo (
    .wr_clock(clock),
    .rd_clock(tx_fast_clock),
    .arst_n(arst_n),
    .wr_valid(tx_valid),
    .wr_data({tx_last, tx_data}),
    .wr_ready(tx_ready),
    .rd_valid(fifo_valid),
    .rd_data(fifo_word),
    .rd_ready(fifo_pop)
  );
  sync3 #(.W(2)) u_tx_mode (
    .clk(tx_fast_clock), .arst_n(arst_n), .d(p0_mode), .q(tx_mode_raw)
  );
  sync3 #(.W(1)) u_txclk (
    .clk(tx_fast_clock), .arst_n(arst_n), .d(p0_transmit_clock_in), .q(txclk_lvl)
  );
  assign tx_mode = port_mode_type'(tx_mode_raw);

  always_comb
  begin
    state_d = state_q;
    half_d = half_q;
    en_d = p0_transmit_enable;
    err_d = p0_transmit_error;
    bus_d = p0_transmit_bus;
    last_sent_d = last_sent_q;
    fifo_pop = 1'b0;
    gtx_d = (tx_mode != mode_mii) && !p0_gigabit_tx_clock_out;
    // launch on tx clock or gigabit rise
    tick = (tx_mode == mode_mii) ? (txclk_lvl && !txclk_prev_q) : !p0_gigabit_tx_clock_out;
    // nothing here ever pauses on received frames
    if (tick && tx_mode == mode_tbi)
    begin
      if (fifo_valid)
      begin
        // enable and error pins as bits 8, 9
        fifo_pop = 1'b1;
        bus_d = fifo_word[7:0];
        en_d = fifo_word[`TX_WORD_BIT8];
        err_d = fifo_word[`TX_WORD_BIT9];
      end
    end
    else if (tick)
    begin
      case (state_q)
        tx_idle, tx_send:
        begin
          if (fifo_valid)
          begin
            en_d = 1'b1;
            err_d = fifo_word[`TX_WORD_BIT9];
            state_d = tx_send;
            last_sent_d = 1'b0;
            if (tx_mode == mode_mii && !half_q)
            begin
              bus_d = {4'h0, fifo_word[3:0]};
              half_d = 1'b1;
            end
            else
            begin
              bus_d = (tx_mode == mode_mii) ? {4'h0, fifo_word[7:4]} : fifo_word[7:0];
              half_d = 1'b0;
              fifo_pop = 1'b1;
              if (fifo_word[`TX_WORD_LAST])
              begin
                state_d = tx_gap;
                last_sent_d = 1'b1;
              end
            end
          end
          else if (state_q == tx_send)
          begin
            err_d = 1'b1;
            bus_d = 8'h00;
          end
          else
          begin
            en_d = 1'b0;
            err_d = 1'b0;
          end
        end
        default:
        begin
          // enable drops after the last data
          en_d = 1'b0;
          err_d = 1'b0;
          bus_d = 8'h00;
          state_d = tx_idle;
        end
      endcase
    end
  end
  always_ff @(posedge tx_fast_clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= tx_idle;
      half_q <= 1'b0;
      txclk_prev_q <= 1'b0;
      last_sent_q <= 1'b0;
      p0_transmit_bus <= 8'h00;
      p0_transmit_enable <= 1'b0;
      p0_transmit_error <= 1'b0;
      p0_gigabit_tx_clock_out <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      half_q <= half_d;
      txclk_prev_q <= txclk_lvl;
      last_sent_q <= last_sent_d;
      p0_transmit_bus <= bus_d;
      p0_transmit_enable <= en_d;
      p0_transmit_error <= err_d;
      p0_gigabit_tx_clock_out <= gtx_d;
    end
  end

  // ---------------- port 1, mii only
  logic [3:0] p1_rx_d;
  logic p1_dv_d, p1_fe_d, p1_fc_d;
  always_comb
  begin
    p1_rx_d = p1_receive_bus;
    p1_dv_d = p1_receive_valid;
    p1_fe_d = p1_receive_valid && p1_receive_error;
    p1_fc_d = false_carrier(p1_receive_valid, p1_receive_error, {4'h0, p1_receive_bus}, 1'b1);
  end
  always_ff @(posedge p1_receive_clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      p1_rx_data <= 4'h0;
      p1_rx_data_valid <= 1'b0;
      p1_rx_frame_error <= 1'b0;
      p1_rx_false_carrier <= 1'b0;
    end
    else
    begin
      p1_rx_data <= p1_rx_d;
      p1_rx_data_valid <= p1_dv_d;
      p1_rx_frame_error <= p1_fe_d;
      p1_rx_false_carrier <= p1_fc_d;
    end
  end
  // launched on port 1 tx clock
  always_ff @(posedge p1_transmit_clock_in or negedge arst_n)
  begin
    if (!arst_n)
    begin
      p1_transmit_bus <= 4'h0;
      p1_transmit_enable <= 1'b0;
      p1_transmit_error <= 1'b0;
    end
    else
    begin
      p1_transmit_bus <= p1_tx_valid ? p1_tx_data : 4'h0;
      p1_transmit_enable <= p1_tx_valid;
      p1_transmit_error <= p1_tx_valid && p1_tx_error;
    end
  end

  // ---------------- checks
  a_frame_error_cause: assert property (@(posedge p0_receive_clock) disable iff (!arst_n)
    p0_rx_frame_error |-> p0_rx_data_valid && $past(p0_receive_error))
    else $error("frame error without valid data");
  a_false_carrier_cause: assert property (@(posedge p1_receive_clock) disable iff (!arst_n)
    p1_rx_false_carrier |-> !p1_rx_data_valid && $past(p1_receive_bus) == 4'he)
    else $error("false carrier without its code");
  a_mii_low_nibble: assert property (@(posedge p0_receive_clock) disable iff (!arst_n)
    rx_mii |=> p0_rx_data[7:4] == 4'h0)
    else $error("upper nibble used in mii");
  a_tbi_phase_a: assert property (@(posedge rx_byte_clock_phase_a) disable iff (!arst_n)
    ##1 p0_tbi_code_a[9:8] == $past({p0_receive_error, p0_receive_valid}))
    else $error("tbi bits 8 and 9 not from valid and error");
  a_carrier_filter: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(p1_carrier_detect) |-> $past(p1_carrier_sense, 3) && $past(p1_carrier_sense, 4))
    else $error("carrier taken before two agreeing samples");
  a_led_active_low: assert property (@(posedge clock) disable iff (!arst_n)
    ##1 p0_link_indicator_n == !$past(p0_link_up) && p1_link_indicator_n == !$past(p1_link_up))
    else $error("link indicator not active low");
  a_enable_frame_end: assert property (@(posedge tx_fast_clock) disable iff (!arst_n)
    $fell(p0_transmit_enable) && tx_mode != mode_tbi |-> last_sent_q)
    else $error("enable dropped before last data");
  a_error_with_enable: assert property (@(posedge tx_fast_clock) disable iff (!arst_n)
    p0_transmit_error && tx_mode != mode_tbi |-> p0_transmit_enable)
    else $error("transmit error outside a frame");
  a_gtx_toggle: assert property (@(posedge tx_fast_clock) disable iff (!arst_n)
    tx_mode == mode_gmii [*2] |-> p0_gigabit_tx_clock_out != $past(p0_gigabit_tx_clock_out))
    else $error("gigabit clock not running");
  a_autoneg_default: assert property (@(posedge clock) disable iff (!arst_n)
    p0_autoneg_enable |-> $past(autoneg_request))
    else $error("auto-negotiation enabled unasked");
endmodule

// [ethernet_port_media_interface_tb_top.sv]
/*
  self-checking bench of the packet port media interface.
  assumes the phy model drives all receive and sense pins and the media clocks.
*/
`timescale 1ns/10ps
module ethernet_port_media_interface_tb_top;
  import eth_media_pkg::*;
  logic clock, arst_n, tx_fast_clock, p0_link_up, p1_link_up, autoneg_request;
  logic tx_valid, tx_last, p1_tx_valid, p1_tx_error;
  port_mode_type p0_mode;
  logic [9:0] tx_data;
  logic [3:0] p1_tx_data;
  logic p0_receive_clock, rx_byte_clock_phase_a, rx_byte_clock_phase_b;
  logic p0_transmit_clock_in, p1_receive_clock, p1_transmit_clock_in;
  logic [7:0] p0_receive_bus;
  logic p0_receive_valid, p0_receive_error, p0_collision_in, p0_carrier_sense;
  logic p0_signal_present, p1_receive_valid, p1_receive_error, p1_collision_in;
  logic p1_carrier_sense, p0_autoneg_enable, tx_ready;
  logic [3:0] p1_receive_bus, p1_rx_data, p1_transmit_bus;
  logic [7:0] p0_rx_data, p0_transmit_bus;
  logic [9:0] p0_tbi_code_a, p0_tbi_code_b;
  logic p0_rx_data_valid, p0_rx_frame_error, p0_rx_false_carrier;
  logic p0_carrier_detect, p0_collision_detect, p0_transmit_enable, p0_transmit_error;
  logic p0_gigabit_tx_clock_out, p0_link_indicator_n, p0_activity_indicator_n;
  logic p1_rx_data_valid, p1_rx_frame_error, p1_rx_false_carrier, p1_carrier_detect;
  logic p1_collision_detect, p1_transmit_enable, p1_transmit_error;
  logic p1_link_indicator_n, p1_activity_indicator_n;
  int n_fail, num_checks, holes, exp_n, refused;
  logic [1:0] mon;
  logic tbi_seen;
  logic [7:0] txq[$];

  ethernet_port_media_interface u_dut (.clock, .arst_n, .tx_fast_clock, .p0_receive_clock,
    .rx_byte_clock_phase_a, .rx_byte_clock_phase_b, .p0_transmit_clock_in, .p1_receive_clock,
    .p1_transmit_clock_in, .p0_mode, .p0_link_up, .p1_link_up, .autoneg_request,
    .p0_autoneg_enable, .tx_valid, .tx_data, .tx_last, .tx_ready, .p0_receive_bus,
    .p0_receive_valid, .p0_receive_error, .p0_collision_in, .p0_carrier_sense,
    .p0_signal_present, .p0_rx_data, .p0_rx_data_valid, .p0_rx_frame_error,
    .p0_rx_false_carrier, .p0_tbi_code_a, .p0_tbi_code_b, .p0_carrier_detect,
    .p0_collision_detect, .p0_transmit_bus, .p0_transmit_enable, .p0_transmit_error,
    .p0_gigabit_tx_clock_out, .p0_link_indicator_n, .p0_activity_indicator_n,
    .p1_receive_bus, .p1_receive_valid, .p1_receive_error, .p1_collision_in,
    .p1_carrier_sense, .p1_rx_data, .p1_rx_data_valid, .p1_rx_frame_error,
    .p1_rx_false_carrier, .p1_carrier_detect, .p1_collision_detect, .p1_tx_valid,
    .p1_tx_data, .p1_tx_error, .p1_transmit_bus, .p1_transmit_enable, .p1_transmit_error,
    .p1_link_indicator_n, .p1_activity_indicator_n);

  eth_phy_model u_phy (.p0_receive_clock, .rx_byte_clock_phase_a, .rx_byte_clock_phase_b,
    .p0_transmit_clock_in, .p1_receive_clock, .p1_transmit_clock_in, .p0_receive_bus,
    .p0_receive_valid, .p0_receive_error, .p0_collision_in, .p0_carrier_sense,
    .p0_signal_present, .p1_receive_bus, .p1_receive_valid, .p1_receive_error,
    .p1_collision_in, .p1_carrier_sense);

  always #12.5 clock = ~clock;
  always #2 tx_fast_clock = ~tx_fast_clock;

  task close_out;
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // frame bytes only; underrun symbols carry the error flag
  task grab(input logic [7:0] b);
    if (p0_transmit_enable === 1'b1 && p0_transmit_error === 1'b0)
      txq.push_back(b);
    else if (p0_transmit_enable !== 1'b1 && txq.size() > 0 && txq.size() < exp_n)
      holes++;
  endtask
  always @(negedge p0_gigabit_tx_clock_out)
  begin
    if (mon == 2'd1)
      grab(p0_transmit_bus);
    if (mon == 2'd3 && {p0_transmit_error, p0_transmit_enable, p0_transmit_bus} === 10'h2a5)
      tbi_seen = 1'b1;
  end
  // pins launched on the previous tick are still standing here
  always @(posedge p0_transmit_clock_in)
    if (mon == 2'd2)
      grab({4'h0, p0_transmit_bus[3:0]});

  task set_mode(input port_mode_type m);
    @(negedge clock);
    p0_mode = m;
    repeat (20) @(negedge clock);
  endtask

  task push(input logic [9:0] d, input logic last);
    tx_valid = 1'b1;
    tx_data = d;
    tx_last = last;
    while (!tx_ready)
    begin
      refused++;
      @(negedge clock);
    end
    @(negedge clock);
  endtask

  task t_sense;
    p0_link_up = 1'b1;
    p1_link_up = 1'b1;
    u_phy.sense(5'b11011);
    repeat (12) @(negedge clock);
    chk({p0_link_indicator_n, p1_link_indicator_n, p0_activity_indicator_n,
      p1_activity_indicator_n, p0_carrier_detect, p0_collision_detect, p1_carrier_detect,
      p1_collision_detect}, 12'h00f);
    p0_link_up = 1'b0;
    u_phy.sense(5'b00010);
    repeat (12) @(negedge clock);
    chk({p0_link_indicator_n, p1_link_indicator_n, p0_activity_indicator_n,
      p1_activity_indicator_n, p0_carrier_detect, p0_collision_detect, p1_carrier_detect,
      p1_collision_detect}, 12'h0a2);
    set_mode(mode_tbi);
    u_phy.sense(5'b00100);
    repeat (12) @(negedge clock);
    chk(p0_carrier_detect, 12'h001);
    u_phy.sense(5'b00000);
  endtask

  task tbi_one(input logic [9:0] v);
    u_phy.p0_drive(v, 1'b1);
    repeat (3) @(posedge rx_byte_clock_phase_a);
    #1;
    chk(p0_tbi_code_a, v);
    chk(p0_tbi_code_b, v);
  endtask

  task t_autoneg;
    @(negedge clock);
    autoneg_request = 1'b1;
    repeat (3) @(negedge clock);
    chk(p0_autoneg_enable, 12'h001);
    set_mode(mode_mii);
    chk(p0_autoneg_enable, 12'h000);
    autoneg_request = 1'b0;
  endtask

  task rx_p0(input logic [9:0] w, input logic [10:0] exp);
    u_phy.p0_drive(w, 1'b0);
    repeat (2) @(posedge p0_receive_clock);
    #1;
    chk({p0_rx_data_valid, p0_rx_frame_error, p0_rx_false_carrier,
      p0_rx_data_valid ? p0_rx_data : 8'h00}, exp);
    u_phy.p0_drive({2'b00, ~w[7:0]}, 1'b0);
  endtask

  task tx_frame(input port_mode_type m, input logic [1:0] kind, input int n, input int base);
    int i;
    logic [7:0] b;
    set_mode(m);
    txq.delete();
    holes = 0;
    refused = 0;
    exp_n = (m == mode_mii) ? 2 * n : n;
    mon = kind;
    for (i = 0; i < n; i++)
      push(10'(base + i), i == n - 1);
    tx_valid = 1'b0;
    tx_last = 1'b0;
    for (i = 0; i < 400 && txq.size() < exp_n; i++)
      @(negedge clock);
    repeat (10) @(negedge clock);
    mon = 2'd0;
    chk(txq.size(), exp_n);
    chk(holes, 0);
    chk(refused != 0, m == mode_mii);
    chk(tx_ready, 12'h001);
    if (m == mode_mii)
      chk(p0_gigabit_tx_clock_out, 12'h000);
    for (i = 0; i < txq.size() && i < exp_n; i++)
    begin
      b = (m == mode_mii) ? 8'(base + i / 2) : 8'(base + i);
      if (m == mode_mii)
        b = i[0] ? {4'h0, b[7:4]} : {4'h0, b[3:0]};
      chk(txq[i], b);
    end
  endtask

  task t_p1;
    u_phy.p1_drive(6'h3c);
    repeat (2) @(posedge p1_receive_clock);
    #1;
    chk({p1_rx_data_valid, p1_rx_frame_error, p1_rx_false_carrier, p1_rx_data}, 12'h06c);
    u_phy.p1_drive(6'h2e);
    repeat (2) @(posedge p1_receive_clock);
    #1;
    chk({p1_rx_data_valid, p1_rx_frame_error, p1_rx_false_carrier}, 12'h001);
    u_phy.p1_drive(6'h01);
    @(negedge p1_transmit_clock_in);
    {p1_tx_valid, p1_tx_error, p1_tx_data} = 6'h2f;
    repeat (2) @(posedge p1_transmit_clock_in);
    #1;
    chk({p1_transmit_enable, p1_transmit_error, p1_transmit_bus}, 12'h02f);
    @(negedge p1_transmit_clock_in);
    p1_tx_error = 1'b1;
    repeat (2) @(posedge p1_transmit_clock_in);
    #1;
    chk({p1_transmit_enable, p1_transmit_error, p1_transmit_bus}, 12'h03f);
    @(negedge p1_transmit_clock_in);
    {p1_tx_valid, p1_tx_error} = 2'b00;
    repeat (2) @(posedge p1_transmit_clock_in);
    #1;
    chk(p1_transmit_enable, 12'h000);
  endtask

  initial
  begin
    #300000;
    n_fail++;
    close_out;
  end

  initial
  begin
    {clock, tx_fast_clock, arst_n, p0_link_up, p1_link_up, autoneg_request} = 6'h00;
    {tx_valid, tx_last, tx_data, p1_tx_valid, p1_tx_error, p1_tx_data} = 18'h00000;
    p0_mode = mode_mii;
    {n_fail, num_checks, holes, exp_n, refused} = {5{32'sd0}};
    mon = 2'd0;
    tbi_seen = 1'b0;
    repeat (16) @(negedge clock);
    chk({p0_link_indicator_n, p0_activity_indicator_n, p1_link_indicator_n,
      p1_activity_indicator_n, tx_ready, p0_transmit_enable}, 12'h03c);
    arst_n = 1'b1;
    repeat (8) @(negedge clock);
    t_sense;
    tbi_one(10'h2c7);
    tbi_one(10'h138);
    t_autoneg;
    rx_p0({2'b01, 8'h5a}, {3'b100, 8'h0a});
    rx_p0({2'b11, 8'h5a}, {3'b110, 8'h0a});
    rx_p0({2'b10, 8'h3e}, {3'b001, 8'h00});
    set_mode(mode_gmii);
    rx_p0({2'b01, 8'ha5}, {3'b100, 8'ha5});
    rx_p0({2'b10, 8'h0e}, {3'b001, 8'h00});
    rx_p0({2'b10, 8'h0d}, {3'b000, 8'h00});
    // bit 8 set in gmii words must not reach the pins
    tx_frame(mode_gmii, 2'd1, 6, 'h110);
    // long enough that the slow mii drain fills the buffer
    tx_frame(mode_mii, 2'd2, 60, 'h80);
    set_mode(mode_tbi);
    mon = 2'd3;
    push(10'h2a5, 1'b1);
    tx_valid = 1'b0;
    repeat (40) @(negedge clock);
    mon = 2'd0;
    chk(tbi_seen, 12'h001);
    t_p1;
    close_out;
  end
endmodule
